// file: logic/nd_pkg.sv
// Purpose: shared constants and helpers for the main divider word decoder
// Assumes: 32-bit AXI4-Lite register access, 4-bit byte address space
// Notes:   counts and widths are module-independent facts of the divider

package nd_pkg;

  // register byte offsets
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] OFS_WORD   = 4'h0;
  localparam logic [3:0] OFS_CTRL   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_FIELDS = 4'hC;

  // programming word layout
  localparam int         WORD_W        = 24;
  localparam int         PAYLOAD_W     = 23;
  localparam int         INT_W         = 11;
  localparam int         FRAC_W        = 12;
  localparam int         INT_LSB       = 13;
  localparam int         FRAC_LSB      = 1;
  localparam int         ADDR_BIT      = 0;
  localparam logic       ADDR_BIT_MAIN = 1'b0;

  // counter fields and prescaler bases
  localparam int         C_W     = 6;
  localparam int         B_W     = 3;
  localparam int         A_W     = 2;
  localparam int         CNT_W   = 12;
  localparam logic [6:0] BASE_LO = 7'h10;
  localparam logic [6:0] BASE_HI = 7'h20;

  // control register fields
  localparam int CTRL_PSEL_BIT  = 0;
  localparam int CTRL_ORDER_LSB = 1;
  localparam int CTRL_RUN_BIT   = 3;

  // field readback positions
  localparam int FLD_B_LSB = 8;
  localparam int FLD_A_LSB = 16;
  localparam int FLD_D_LSB = 24;

  // reset values
  localparam logic [INT_W-1:0]  INT_RST   = 11'h050;
  localparam logic [FRAC_W-1:0] FRAC_RST  = 12'h000;
  localparam logic              PSEL_RST  = 1'b0;
  localparam logic [1:0]        ORDER_RST = 2'h1;
  localparam logic              RUN_RST   = 1'b0;

  // modulator
  localparam int MAX_ORDER = 4;
  localparam int DELTA_W   = 5;
  typedef logic signed [DELTA_W-1:0] delta_t;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // total divide of the four-modulus prescaler: base*C + 4*B + A
  function automatic logic [CNT_W-1:0] total_divide(input logic psel, input logic [C_W-1:0] c,
                                                     input logic [B_W-1:0] b, input logic [A_W-1:0] a);
    logic [CNT_W-1:0] base;
    base = psel ? CNT_W'(BASE_HI) : CNT_W'(BASE_LO);
    return CNT_W'(base * CNT_W'(c)) + CNT_W'({b, 2'h0}) + CNT_W'(a);
  endfunction : total_divide

endpackage : nd_pkg

// file: logic/div_link_if.sv
// Purpose: link between word decoder, modulator and feedback counter
// Assumes: single clock domain
// Notes:   step is the feedback period boundary seen by the modulator
`timescale 1ns/10ps
`default_nettype none

interface div_link_if;
  import nd_pkg::*;
  logic              step;
  logic [FRAC_W-1:0] numerator;
  logic [1:0]        order;
  delta_t            delta;
  logic [C_W-1:0]    c;
  logic [B_W-1:0]    b;
  logic [A_W-1:0]    a;
  logic              psel;
  logic              run;
  logic              fb_pulse;

  modport modulator (input step, numerator, order, output delta);
  modport counter   (input c, b, a, psel, run, output fb_pulse);
  modport ctrl      (output step, numerator, order, c, b, a, psel, run, input delta, fb_pulse);
endinterface : div_link_if

`default_nettype wire

// file: logic/sd_modulator.sv
// Purpose: cascaded accumulator delta-sigma modulator, order 1 to 4
// Assumes: fixed fractional denominator of 2**FRAC_W
// Notes:   stages above the selected order are held idle and cleared
`timescale 1ns/10ps
`default_nettype none

module sd_modulator (
  // clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      clk_en,
  // link
  div_link_if.modulator  lnk
);
  import nd_pkg::*;

  logic [FRAC_W-1:0] acc_reg  [MAX_ORDER];
  delta_t            hist_reg [MAX_ORDER];
  delta_t            delta_reg;
  logic [FRAC_W-1:0] res_next [MAX_ORDER];
  delta_t            y_next   [MAX_ORDER];
  logic [FRAC_W:0]   sum_v;
  logic [FRAC_W-1:0] in_v;
  logic              carry_v;
  delta_t            y_up;
  delta_t            h_up;

  // stage sums and noise-cancelling recombination, last stage first
  always_comb begin
    in_v = lnk.numerator;
    sum_v = '0;
    carry_v = 1'b0;
    y_up = '0;
    h_up = '0;
    for (int k = 0; k < MAX_ORDER; k++) begin
      sum_v = {1'b0, acc_reg[k]} + {1'b0, in_v};
      res_next[k] = (k <= int'(lnk.order)) ? sum_v[FRAC_W-1:0] : '0;
      in_v = sum_v[FRAC_W-1:0];
    end
    for (int k = MAX_ORDER - 1; k >= 0; k--) begin
      sum_v = {1'b0, acc_reg[k]} + {1'b0, (k == 0) ? lnk.numerator : res_next[(k > 0) ? k - 1 : 0]};
      carry_v = (k <= int'(lnk.order)) & sum_v[FRAC_W];
      y_next[k] = delta_t'({1'b0, carry_v}) + y_up - h_up;
      y_up = y_next[k];
      h_up = hist_reg[k];
    end
  end

  // advance once per feedback period; delta applies to the next period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < MAX_ORDER; k++) begin
        acc_reg[k]  <= '0;
        hist_reg[k] <= '0;
      end
      delta_reg <= '0;
    end else if (clk_en && lnk.step) begin
      for (int k = 0; k < MAX_ORDER; k++) begin
        acc_reg[k]  <= res_next[k];
        hist_reg[k] <= y_next[k];
      end
      delta_reg <= y_next[0];
    end
  end

  assign lnk.delta = delta_reg;

endmodule : sd_modulator

`default_nettype wire

// file: logic/fb_counter.sv
// Purpose: main loop feedback counter with two four-modulus bases
// Assumes: each enabled clock stands for one prescaler input edge
// Notes:   fields are sampled only at the period boundary
`timescale 1ns/10ps
`default_nettype none

module fb_counter (
  // clock and reset
  input  wire logic    aclk,
  input  wire logic    aresetn,
  input  wire logic    clk_en,
  // link
  div_link_if.counter  lnk
);
  import nd_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic             pulse_reg;
  logic [CNT_W-1:0] total;

  assign total = total_divide(lnk.psel, lnk.c, lnk.b, lnk.a);

  // count down one period of total divide, pulse at its start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end else if (clk_en) begin
      if (!lnk.run) begin
        cnt_reg   <= '0;
        pulse_reg <= 1'b0;
      end else if (cnt_reg == '0) begin
        cnt_reg   <= (total < CNT_W'(2)) ? '0 : total - CNT_W'(1);
        pulse_reg <= 1'b1;
      end else begin
        cnt_reg   <= cnt_reg - CNT_W'(1);
        pulse_reg <= 1'b0;
      end
    end
  end

  assign lnk.fb_pulse = pulse_reg;

endmodule : fb_counter

`default_nettype wire

// file: logic/main_divider.sv
// Purpose: main divider word decoder with AXI4-Lite register access
// Assumes: single clock, synchronous active-low reset, clock enable
// Notes:   fields are re-split every cycle from the modulated divide
//
// What this block does
// - Words carry 20-bit payloads; the main divider word carries 23.
// - Main divider word is recognised by address bit 0 being zero.
// - One write updates integer divide and fractional numerator together.
// - Integer divide sits in bits 23..13, numerator in bits 12..1.
// - Integer splits into C, B, A; divide is base*C + 4*B + A.
// - Unused B bit is taken by the modulator for its own swing.
// - Feedback counter offers base-16 and base-32 four-modulus sets.
// - One prescaler select bit: clear picks base 16, set picks base 32.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module main_divider (
  // clock, reset and enable
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       clk_en,
  // write address channel
  input  wire logic                       awvalid,
  output var  logic                       awready,
  input  wire logic [nd_pkg::ADDR_W-1:0]  awaddr,
  // write data channel
  input  wire logic                       wvalid,
  output var  logic                       wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  // write response channel
  output var  logic                       bvalid,
  input  wire logic                       bready,
  output var  logic [1:0]                 bresp,
  // read address channel
  input  wire logic                       arvalid,
  output var  logic                       arready,
  input  wire logic [nd_pkg::ADDR_W-1:0]  araddr,
  // read data channel
  output var  logic                       rvalid,
  input  wire logic                       rready,
  output var  logic [31:0]                rdata,
  output var  logic [1:0]                 rresp,
  // feedback
  output var  logic                       feedback_pulse
);
  import nd_pkg::*;

  div_link_if lnk ();

  // held write request
  logic              aw_held_reg;
  logic [3:0]        awaddr_reg;
  logic              w_held_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              do_write;
  logic [1:0]        wr_resp;

  // programmed state
  logic [INT_W-1:0]  main_integer_divide_reg;
  logic [FRAC_W-1:0] main_fraction_numerator_reg;
  logic              prescaler_select_reg;
  logic [1:0]        modulator_order_reg;
  logic              run_reg;

  // counter fields
  logic [C_W-1:0]    coarse_count_field_reg;
  logic [B_W-1:0]    mid_count_field_reg;
  logic [A_W-1:0]    fine_count_field_reg;
  logic [C_W-1:0]    coarse_next;
  logic [B_W-1:0]    mid_next;
  logic [A_W-1:0]    fine_next;

  // read path
  logic [31:0]       rd_data;
  logic [1:0]        rd_resp;

  // register word select, low address bits ignored
  function automatic logic [3:0] word_sel(input logic [ADDR_W-1:0] addr);
    return {addr[3:2], 2'h0};
  endfunction : word_sel

  // response for a write, judged on address, payload tag and lanes
  function automatic logic [1:0] write_resp(input logic [3:0] addr, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [1:0] resp;
    resp = RESP_DECERR;
    case (word_sel(addr))
      OFS_WORD:   resp = (data[ADDR_BIT] == ADDR_BIT_MAIN && (&strb[2:0])) ? RESP_OKAY : RESP_SLVERR;
      OFS_CTRL:   resp = RESP_OKAY;
      OFS_STATUS: resp = RESP_SLVERR;
      OFS_FIELDS: resp = RESP_SLVERR;
      default:    resp = RESP_DECERR;
    endcase
    return resp;
  endfunction : write_resp

  assign do_write = aw_held_reg && w_held_reg && !bvalid;
  assign wr_resp  = write_resp(awaddr_reg, wdata_reg, wstrb_reg);

  // write address capture; ready drops while an address is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
      awready     <= 1'b1;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= awaddr;
        awready     <= 1'b0;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
        awready     <= 1'b1;
      end
    end
  end

  // write data capture, independent of the address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
      wready     <= 1'b1;
    end else if (clk_en) begin
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
        wready     <= 1'b0;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
        wready     <= 1'b1;
      end
    end
  end

  // write response; a second write waits until this one is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_resp;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // main divider word: both values land in the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_integer_divide_reg     <= INT_RST;
      main_fraction_numerator_reg <= FRAC_RST;
    end else if (clk_en && do_write && word_sel(awaddr_reg) == OFS_WORD && wr_resp == RESP_OKAY) begin
      main_integer_divide_reg     <= wdata_reg[INT_LSB +: INT_W];
      main_fraction_numerator_reg <= wdata_reg[FRAC_LSB +: FRAC_W];
    end
  end

  // control register; only byte lane 0 carries the bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler_select_reg <= PSEL_RST;
      modulator_order_reg  <= ORDER_RST;
      run_reg              <= RUN_RST;
    end else if (clk_en && do_write && word_sel(awaddr_reg) == OFS_CTRL && wstrb_reg[0]) begin
      prescaler_select_reg <= wdata_reg[CTRL_PSEL_BIT];
      modulator_order_reg  <= wdata_reg[CTRL_ORDER_LSB +: 2];
      run_reg              <= wdata_reg[CTRL_RUN_BIT];
    end
  end

  // split the modulated divide into counter fields
  always_comb begin
    logic signed [CNT_W:0] v;
    logic signed [CNT_W:0] rem;
    logic [C_W-1:0]        cn;
    cn  = '0;
    rem = '0;
    v   = $signed({2'h0, main_integer_divide_reg}) + (CNT_W+1)'(lnk.delta);
    if (v < 0) begin
      v = '0;
    end
    cn  = main_integer_divide_reg[4 +: C_W];
    rem = v - $signed({3'h0, cn, 4'h0});
    if (prescaler_select_reg) begin
      coarse_next = v[5 +: C_W];
      mid_next    = v[2 +: B_W];
      fine_next   = v[0 +: A_W];
    end else if (rem >= 0 && rem < 32) begin
      // spare B bit absorbs upward swing
      coarse_next = cn;
      mid_next    = rem[2 +: B_W];
      fine_next   = rem[0 +: A_W];
    end else begin
      // base-16 split, top B bit unused
      coarse_next = v[4 +: C_W];
      mid_next    = {1'b0, v[3:2]};
      fine_next   = v[0 +: A_W];
    end
  end

  // field registers feed the counter; it samples them at reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coarse_count_field_reg <= '0;
      mid_count_field_reg    <= '0;
      fine_count_field_reg   <= '0;
    end else if (clk_en) begin
      coarse_count_field_reg <= coarse_next;
      mid_count_field_reg    <= mid_next;
      fine_count_field_reg   <= fine_next;
    end
  end

  // link wiring to the modulator and counter
  assign lnk.step      = lnk.fb_pulse;
  assign lnk.numerator = main_fraction_numerator_reg;
  assign lnk.order     = modulator_order_reg;
  assign lnk.c         = coarse_count_field_reg;
  assign lnk.b         = mid_count_field_reg;
  assign lnk.a         = fine_count_field_reg;
  assign lnk.psel      = prescaler_select_reg;
  assign lnk.run       = run_reg;

  sd_modulator u_mod (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .lnk     (lnk)
  );

  fb_counter u_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .lnk     (lnk)
  );

  // read mux; the word register is write-only and reads zero
  always_comb begin
    rd_data = '0;
    rd_resp = RESP_OKAY;
    case (word_sel(araddr))
      OFS_WORD: begin
        rd_data = '0;
      end
      OFS_CTRL: begin
        rd_data[CTRL_PSEL_BIT]       = prescaler_select_reg;
        rd_data[CTRL_ORDER_LSB +: 2] = modulator_order_reg;
        rd_data[CTRL_RUN_BIT]        = run_reg;
      end
      OFS_STATUS: begin
        rd_data[INT_LSB +: INT_W]   = main_integer_divide_reg;
        rd_data[FRAC_LSB +: FRAC_W] = main_fraction_numerator_reg;
      end
      OFS_FIELDS: begin
        rd_data[0 +: C_W]             = coarse_count_field_reg;
        rd_data[FLD_B_LSB +: B_W]     = mid_count_field_reg;
        rd_data[FLD_A_LSB +: A_W]     = fine_count_field_reg;
        rd_data[FLD_D_LSB +: DELTA_W] = lnk.delta;
      end
      default: begin
        rd_resp = RESP_DECERR;
      end
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data;
        rresp   <= rd_resp;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // registered copy keeps the port straight from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feedback_pulse <= 1'b0;
    end else if (clk_en) begin
      feedback_pulse <= lnk.fb_pulse;
    end
  end

endmodule : main_divider

`default_nettype wire

// file: verif/main_divider_checker.sv
// Purpose: bus handshake and word decode checks at the main divider ports
// Assumes: the host offers write address and data together
// Notes:   a low clock enable freezes the block, so checking pauses with it
`timescale 1ns/10ps
`default_nettype none

module main_divider_checker (
  // clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      clk_en,
  // write channels
  input wire logic                      awvalid,
  input wire logic                      awready,
  input wire logic [nd_pkg::ADDR_W-1:0] awaddr,
  input wire logic                      wvalid,
  input wire logic                      wready,
  input wire logic [31:0]               wdata,
  input wire logic [3:0]                wstrb,
  input wire logic                      bvalid,
  input wire logic                      bready,
  input wire logic [1:0]                bresp,
  // read channels
  input wire logic                      arvalid,
  input wire logic                      arready,
  input wire logic [nd_pkg::ADDR_W-1:0] araddr,
  input wire logic                      rvalid,
  input wire logic                      rready,
  input wire logic [31:0]               rdata,
  input wire logic [1:0]                rresp,
  // feedback
  input wire logic                      feedback_pulse
);
  import nd_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  logic both_taken;
  // both write halves taken on one edge
  assign both_taken = awvalid && awready && wvalid && wready;

  // the held halves launch the response one edge after the take
  AST_WRITE_ANSWER: assert property (both_taken && (!bvalid || bready) |=> (!awready && !wready) ##1 bvalid)
    else $error("write response not raised two cycles after the take");
  AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before acceptance");
  AST_BRESP_DONE: assert property (bvalid && bready |=> !bvalid)
    else $error("write response still up after acceptance");
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not raised one cycle after the take");
  AST_RDATA_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before acceptance");
  AST_READ_DONE: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not freed after acceptance");
  AST_ADDR_BIT_SET: assert property (
    both_taken && awaddr == OFS_WORD && wdata[ADDR_BIT] != ADDR_BIT_MAIN |-> ##2 bresp == RESP_SLVERR)
    else $error("word with address bit set was accepted");
  AST_WORD_TAKEN: assert property (
    both_taken && awaddr == OFS_WORD && wdata[ADDR_BIT] == ADDR_BIT_MAIN && wstrb[2:0] == 3'h7
    |-> ##2 bresp == RESP_OKAY)
    else $error("main word write refused");
  // low address bits are ignored, so any address in the first word reads the write-only word
  AST_WORD_READ_ZERO: assert property (arvalid && arready && araddr[3:2] == 2'h0
    |=> rresp == RESP_OKAY && rdata == 32'h0)
    else $error("write-only word read not zero with okay");

  COV_WRITE: cover property (bvalid && bready);
  COV_READ: cover property (rvalid && rready);
  COV_PULSE: cover property (feedback_pulse ##[2:300] feedback_pulse);
endmodule : main_divider_checker

bind main_divider main_divider_checker u_main_divider_checker (.aclk, .aresetn, .clk_en, .awvalid, .awready,
  .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
  .rready, .rdata, .rresp, .feedback_pulse);
`default_nettype wire

// file: verif/axi_host_model.sv
// Purpose: host that programs the divider over the register bus
// Assumes: one write and one read at most under way
// Notes:   gap adds idle cycles before each request and a late bready or rready for a slow host
`timescale 1ns/10ps
`default_nettype none

module axi_host_model (
  // clock
  input  wire logic                      aclk,
  // write channels
  output var  logic                      awvalid,
  input  wire logic                      awready,
  output var  logic [nd_pkg::ADDR_W-1:0] awaddr,
  output var  logic                      wvalid,
  input  wire logic                      wready,
  output var  logic [31:0]               wdata,
  output var  logic [3:0]                wstrb,
  input  wire logic                      bvalid,
  output var  logic                      bready,
  input  wire logic [1:0]                bresp,
  // read channels
  output var  logic                      arvalid,
  input  wire logic                      arready,
  output var  logic [nd_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      rvalid,
  output var  logic                      rready,
  input  wire logic [31:0]               rdata,
  input  wire logic [1:0]                rresp
);
  int gap = 0;
  // answer channels start ready; a slow host raises them only once the answer shows
  initial begin
    awvalid = 1'b0;
    wvalid  = 1'b0;
    arvalid = 1'b0;
    bready  = 1'b1;
    rready  = 1'b1;
    awaddr  = 4'h0;
    araddr  = 4'h0;
    wdata   = 32'h0;
    wstrb   = 4'h0;
  end

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    repeat (gap) @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (gap == 0);
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        break;
      end
      if (bvalid) bready <= 1'b1;
    end
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    repeat (gap) @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= (gap == 0);
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        break;
      end
      if (rvalid) rready <= 1'b1;
    end
  endtask : bus_read
endmodule : axi_host_model
`default_nettype wire

// file: verif/main_divider_test.sv
// Purpose: self-checking bench for the main divider word decoder
// Assumes: clock enable held high throughout
// Notes:   expectations come from the word layout and prescaler bases
`timescale 1ns/10ps
`default_nettype none

module main_divider_test;
  import nd_pkg::*;
  logic              aclk;
  logic              aresetn;
  logic              clk_en;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, feedback_pulse;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rsp;
  int                failures;
  int                checks_done;

  main_divider u_main_divider (.aclk, .aresetn, .clk_en, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .feedback_pulse);
  axi_host_model u_axi_host_model (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // reset values, read-only refusal and a misaligned word read, slow host
  task automatic t_reset_values;
    u_axi_host_model.gap = 3;
    u_axi_host_model.bus_read(OFS_STATUS, rd, rsp);
    check("status", {8'h00, INT_RST, FRAC_RST, 1'b0}, rd);
    u_axi_host_model.bus_read(OFS_CTRL, rd, rsp);
    check("ctrl", {28'h0, RUN_RST, ORDER_RST, PSEL_RST}, rd);
    u_axi_host_model.bus_read(4'h2, rd, rsp);
    check("misaligned resp", 32'(RESP_OKAY), 32'(rsp));
    check("misaligned data", 32'h0, rd);
    u_axi_host_model.bus_write(OFS_STATUS, 32'h0, 4'hF, rsp);
    check("status write resp", 32'(RESP_SLVERR), 32'(rsp));
    u_axi_host_model.gap = 0;
  endtask : t_reset_values

  // one write sets both values, extra top bits ignored, address bit refused
  task automatic t_word_write;
    u_axi_host_model.bus_write(OFS_WORD, {8'hA5, 11'h3FF, 12'hABC, 1'b0}, 4'hF, rsp);
    check("word resp", 32'(RESP_OKAY), 32'(rsp));
    u_axi_host_model.bus_read(OFS_STATUS, rd, rsp);
    check("status", {8'h00, 11'h3FF, 12'hABC, 1'b0}, rd);
    u_axi_host_model.bus_write(OFS_WORD, {8'h00, 11'h123, 12'h456, 1'b1}, 4'hF, rsp);
    check("odd word resp", 32'(RESP_SLVERR), 32'(rsp));
    u_axi_host_model.bus_read(OFS_STATUS, rd, rsp);
    check("status kept", {8'h00, 11'h3FF, 12'hABC, 1'b0}, rd);
  endtask : t_word_write

  // counter split and feedback period for both prescaler sets
  task automatic t_split_and_period;
    logic [10:0] n_tab [4] = '{11'd80, 11'd1023, 11'd231, 11'd2039};
    logic [5:0]  c_tab [4] = '{6'd5, 6'd63, 6'd7, 6'd63};
    logic [2:0]  b_tab [4] = '{3'd0, 3'd3, 3'd1, 3'd5};
    logic [1:0]  a_tab [4] = '{2'd0, 2'd3, 2'd3, 2'd3};
    int          n;
    for (int i = 0; i < 4; i++) begin
      u_axi_host_model.bus_write(OFS_WORD, {8'h00, n_tab[i], 12'h000, 1'b0}, 4'hF, rsp);
      u_axi_host_model.bus_write(OFS_CTRL, {28'h0, 1'b1, 2'h1, 1'(i / 2)}, 4'hF, rsp);
      u_axi_host_model.bus_read(OFS_FIELDS, rd, rsp);
      check("fields", {14'h0, a_tab[i], 5'h0, b_tab[i], 2'h0, c_tab[i]}, rd);
      // the first boundaries may still carry the old fields
      for (int k = 0; k < 3; k++) begin
        n = 0;
        do begin
          @(posedge aclk);
          n++;
        end while (feedback_pulse !== 1'b1 && n < 5000);
      end
      check("period", 32'(n_tab[i]), 32'(n));
    end
  endtask : t_split_and_period

  // base 16 with fraction: spare mid bit keeps the coarse count steady
  task automatic t_spare_bit;
    logic signed [5:0] d;
    for (int ord = 0; ord < 4; ord++) begin
      u_axi_host_model.bus_write(OFS_WORD, {8'h00, 11'd72, 12'h801, 1'b0}, 4'hF, rsp);
      u_axi_host_model.bus_write(OFS_CTRL, {28'h0, 1'b1, 2'(ord), 1'b0}, 4'hF, rsp);
      repeat (8) begin
        // read just after a boundary, when fields and delta agree
        do @(posedge aclk); while (feedback_pulse !== 1'b1);
        u_axi_host_model.bus_read(OFS_FIELDS, rd, rsp);
        d = 6'(signed'(rd[28:24]));
        check("coarse", 32'd4, {26'h0, rd[5:0]});
        check("sum", 32'(72 + d), 32'(16 * rd[5:0] + 4 * rd[10:8] + rd[17:16]));
      end
    end
  endtask : t_spare_bit

  // hang guard
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    aresetn     = 1'b0;
    clk_en      = 1'b1;
    failures    = 0;
    checks_done = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_word_write();
    t_split_and_period();
    t_spare_bit();
    tally_and_finish();
  end
endmodule : main_divider_test
`default_nettype wire
